/* File: rf_transceiver_control_defs.vh */
// Constants for the transceiver control block: register offsets, field
// positions, reset values, mode codes and clock divider ratios.
// Assumes it is included by bare name from the design file.
`ifndef RF_TRANSCEIVER_CONTROL_DEFS_VH
`define RF_TRANSCEIVER_CONTROL_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_CTRL       4'h0
`define ADDR_BAND_A     4'h1
`define ADDR_RATE_A     4'h2
`define ADDR_STATUS     4'h3
`define ADDR_FREQ_0     4'h4
`define ADDR_FREQ_1     4'h5
`define ADDR_FREQ_2     4'h6
`define ADDR_CARRIER    4'h7
`define ADDR_DEVIATION  4'h8
`define ADDR_BAND_B     4'h9
`define ADDR_RATE_B     4'ha

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_LOW_VOLT_DETECT_ENABLE       2
`define CTRL_DME        3
`define CTRL_FSK        4
`define CTRL_FIXED_REF  5
`define CTRL_DIRECT     6
`define CTRL_BANK       7
`define BAND_SEL_LO     0
`define BAND_SEL_HI     1
`define BAND_LO_LO      2
`define BAND_LO_HI      3
`define BAND_LNA_LO     4
`define BAND_LNA_HI     5
`define BAND_PA_LO      6
`define BAND_PA_HI      7
`define RATE_SEL_LO     0
`define RATE_SEL_HI     1
`define RATE_STROBE     2
`define RATE_AUTO_BANK  3

// ************************************************************
// Reset values and codes
// ************************************************************
`define RST_BYTE        8'h00
`define MODE_RX         2'b00
`define MODE_TX         2'b01
`define MODE_STANDBY    2'b10
`define BAND_304_315    2'b00
`define BAND_426_434    2'b01
`define BAND_868_916    2'b11

// ************************************************************
// Clock divider ratios, band bit zero clear and set
// ************************************************************
`define DATA_DIV_LOW    8'd60
`define DATA_DIV_HIGH   8'd80
`define DIG_DIV_LOW     8'd30
`define DIG_DIV_HIGH    8'd40
`define IF_DIV_LOW      8'd9
`define IF_DIV_HIGH     8'd12
`endif

/* File: rf_transceiver_control.v */
// Digital control of a UHF transceiver: clock dividers, supply monitor,
// lock gating, RF switch, data manager, wakeup strobe and frequency words.
// Assumes sys_clk is the crystal reference and reset_n is the power-on reset.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "rf_transceiver_control_defs.vh"

module rf_transceiver_control #(
   parameter STROBE_ON_TICKS  = 16,
   parameter STROBE_OFF_TICKS = 144,
   parameter [23:0] IF_OFFSET = 24'h000400
) (
   // Clock and power-on reset.
   input  wire        sys_clk,
   input  wire        reset_n,
   // Register port.
   input  wire [3:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // Analog and link status pins.
   input  wire        monitored_supply,
   input  wire        pll_lock,
   input  wire        demod_data,
   input  wire        tx_coded_data,
   // Clock enables derived from the crystal.
   output wire        data_clk_en,
   output wire        dig_clk_en,
   output wire        if_ref_en,
   // Receiver and transmitter controls.
   output reg         rf_switch,
   output reg         pa_enable,
   output reg         rx_enable,
   output reg         standby_active,
   output reg         lvd_mode,
   output reg  [1:0]  lna_gain_step,
   output reg  [1:0]  pa_power_step,
   output reg         demod_adaptive,
   output reg  [1:0]  lpf_bandwidth,
   output reg  [3:0]  band_code,
   output reg  [23:0] synth_word,
   // Serial data output toward the microcontroller.
   output reg         serial_data,
   output reg         serial_clk
);

   // ************************************************************
   // Registers
   // ************************************************************
   reg [7:0] ctrl_r, band_a_r, rate_a_r, band_b_r, rate_b_r;
   reg [7:0] freq0_r, freq1_r, freq2_r, carrier_r, deviation_r;
   reg       lvd_status_r;
   reg       bank_r;
   wire      wake_start;

   // Software writes; the wakeup toggles the active bank when auto-switch is on.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r      <= `RST_BYTE;
         band_a_r    <= `RST_BYTE;
         rate_a_r    <= `RST_BYTE;
         band_b_r    <= `RST_BYTE;
         rate_b_r    <= `RST_BYTE;
         freq0_r     <= `RST_BYTE;
         freq1_r     <= `RST_BYTE;
         freq2_r     <= `RST_BYTE;
         carrier_r   <= `RST_BYTE;
         deviation_r <= `RST_BYTE;
         bank_r      <= 1'b0;
      end else begin
         // Standby does not touch these; only writes and reset do.
         if (reg_wr) begin
            case (reg_addr)
               `ADDR_CTRL:      ctrl_r      <= reg_wdata;
               `ADDR_BAND_A:    band_a_r    <= reg_wdata;
               `ADDR_RATE_A:    rate_a_r    <= reg_wdata;
               `ADDR_FREQ_0:    freq0_r     <= reg_wdata;
               `ADDR_FREQ_1:    freq1_r     <= reg_wdata;
               `ADDR_FREQ_2:    freq2_r     <= reg_wdata;
               `ADDR_CARRIER:   carrier_r   <= reg_wdata;
               `ADDR_DEVIATION: deviation_r <= reg_wdata;
               `ADDR_BAND_B:    band_b_r    <= reg_wdata;
               `ADDR_RATE_B:    rate_b_r    <= reg_wdata;
               default: ;
            endcase
         end
         // A command write of the bank bit loads that configuration at once.
         if (reg_wr && reg_addr == `ADDR_CTRL)
            bank_r <= reg_wdata[`CTRL_BANK];
         else if (wake_start && rate_a_r[`RATE_AUTO_BANK])
            bank_r <= ~bank_r;
      end
   end

   // Active configuration picked from the selected bank.
   wire [7:0] band_act = bank_r ? band_b_r : band_a_r;
   wire [7:0] rate_act = bank_r ? rate_b_r : rate_a_r;
   wire [1:0] mode     = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
   wire       low_volt_detect_enable     = ctrl_r[`CTRL_LOW_VOLT_DETECT_ENABLE];
   wire       data_manager_enable      = ctrl_r[`CTRL_DME];
   wire       fsk      = ctrl_r[`CTRL_FSK];
   wire       band0    = band_act[`BAND_SEL_LO];

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Order: supply low, lock, demodulator data, transmit data.
   wire [3:0] pin_raw = {tx_coded_data, demod_data, pll_lock, monitored_supply};
   reg  [3:0] pin_meta_r, pin_sync_r;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   wire supply_low = pin_sync_r[0];
   wire locked     = pin_sync_r[1];
   wire rx_line    = pin_sync_r[2];
   wire tx_line    = pin_sync_r[3];

   // ************************************************************
   // Clock dividers
   // ************************************************************
   // Index 0 data clock, 1 digital clock, 2 IF reference.
   wire [23:0] div_low  = {`IF_DIV_LOW, `DIG_DIV_LOW, `DATA_DIV_LOW};
   wire [23:0] div_high = {`IF_DIV_HIGH, `DIG_DIV_HIGH, `DATA_DIV_HIGH};
   wire [2:0]  div_tick;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_div
         reg  [7:0] cnt_r;
         wire [7:0] ratio = band0 ? div_high[gi*8 +: 8] : div_low[gi*8 +: 8];
         // Counting up to the ratio minus one keeps the enable exactly one cycle wide.
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n)
               cnt_r <= 8'h00;
            else if (cnt_r >= ratio - 8'd1)
               cnt_r <= 8'h00;
            else
               cnt_r <= cnt_r + 8'd1;
         end
         assign div_tick[gi] = (cnt_r == ratio - 8'd1);
      end
   endgenerate

   assign data_clk_en = div_tick[0];
   assign dig_clk_en  = div_tick[1];
   // The 1.5/2 scaling happens in the analog IF filter tuning.
   assign if_ref_en   = div_tick[2];

   // ************************************************************
   // Supply monitor and standby
   // ************************************************************
   wire stat_read = reg_rd && (reg_addr == `ADDR_STATUS);

   // Evaluated on each digital clock tick; a set in the clearing cycle wins.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         lvd_status_r <= 1'b0;
      else if (low_volt_detect_enable && supply_low && dig_clk_en)
         lvd_status_r <= 1'b1;
      else if (stat_read)
         lvd_status_r <= 1'b0;
   end

   // Standby is refused while monitoring is enabled.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         standby_active <= 1'b0;
         lvd_mode       <= 1'b0;
      end else begin
         standby_active <= (mode == `MODE_STANDBY) && !low_volt_detect_enable;
         lvd_mode       <= (mode == `MODE_STANDBY) && low_volt_detect_enable;
      end
   end

   // ************************************************************
   // Wakeup strobe sequencer
   // ************************************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ON   = 3'b010;
   localparam [2:0] ST_OFF  = 3'b100;
   reg [2:0]  wake_st_r;
   reg [15:0] wake_cnt_r;
   wire       strobe_en = rate_a_r[`RATE_STROBE] && (mode == `MODE_RX);

   assign wake_start = strobe_en && data_clk_en &&
                       ((wake_st_r == ST_IDLE) ||
                        ((wake_st_r == ST_OFF) && wake_cnt_r == 16'h0000));

   // The data clock ticks stand in for the low-frequency strobe oscillator.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_st_r  <= ST_IDLE;
         wake_cnt_r <= 16'h0000;
      end else if (!strobe_en) begin
         wake_st_r  <= ST_IDLE;
         wake_cnt_r <= 16'h0000;
      end else if (data_clk_en) begin
         case (wake_st_r)
            ST_IDLE: begin
               wake_st_r  <= ST_ON;
               wake_cnt_r <= STROBE_ON_TICKS[15:0] - 16'd1;
            end
            ST_ON: begin
               if (wake_cnt_r == 16'h0000) begin
                  wake_st_r  <= ST_OFF;
                  wake_cnt_r <= STROBE_OFF_TICKS[15:0] - 16'd1;
               end else
                  wake_cnt_r <= wake_cnt_r - 16'd1;
            end
            ST_OFF: begin
               if (wake_cnt_r == 16'h0000) begin
                  wake_st_r  <= ST_ON;
                  wake_cnt_r <= STROBE_ON_TICKS[15:0] - 16'd1;
               end else
                  wake_cnt_r <= wake_cnt_r - 16'd1;
            end
            default: begin
               wake_st_r  <= ST_IDLE;
               wake_cnt_r <= 16'h0000;
            end
         endcase
      end
   end

   // ************************************************************
   // Manchester data manager
   // ************************************************************
   // Half-bit length in digital clock ticks per rate range.
   reg  [7:0] half_bit;
   always @* begin
      case (rate_act[`RATE_SEL_HI:`RATE_SEL_LO])
         2'b00:   half_bit = 8'd120;
         2'b01:   half_bit = 8'd60;
         2'b10:   half_bit = 8'd30;
         default: half_bit = 8'd15;
      endcase
   end

   reg  [8:0] edge_age_r;
   reg        rx_prev_r;
   reg        dm_data_r;
   reg        dm_strobe_r;
   wire       rx_edge  = rx_line ^ rx_prev_r;
   // An edge at least 3/2 half-bits after the last mid-bit edge is mid-bit.
   wire [8:0] mid_gate = {1'b0, half_bit} + {2'b00, half_bit[7:1]};
   wire       rx_live  = locked && !standby_active && !lvd_mode;

   // Boundary edges are skipped, so the clock is recovered from mid-bit edges.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_prev_r   <= 1'b0;
         edge_age_r  <= 9'h1ff;
         dm_data_r   <= 1'b0;
         dm_strobe_r <= 1'b0;
      end else begin
         rx_prev_r   <= rx_line;
         dm_strobe_r <= 1'b0;
         if (!rx_live || !data_manager_enable) begin
            edge_age_r <= 9'h1ff;
         end else if (rx_edge && edge_age_r >= mid_gate) begin
            dm_data_r   <= rx_line;
            dm_strobe_r <= 1'b1;
            edge_age_r  <= 9'h000;
         end else if (dig_clk_en && edge_age_r != 9'h1ff) begin
            edge_age_r <= edge_age_r + 9'd1;
         end
      end
   end

   // Serial output: master data and clock, or raw shaped data without manager.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_data <= 1'b0;
         serial_clk  <= 1'b0;
      end else if (!rx_live || mode != `MODE_RX) begin
         serial_data <= 1'b0;
         serial_clk  <= 1'b0;
      end else if (data_manager_enable) begin
         if (dm_strobe_r)
            serial_data <= dm_data_r;
         serial_clk <= dm_strobe_r;
      end else begin
         serial_data <= rx_line;
         serial_clk  <= 1'b0;
      end
   end

   // ************************************************************
   // Transmit path, RF switch and synthesizer word
   // ************************************************************
   reg         tx_mode_r;
   wire        tx_mode = (mode == `MODE_TX);
   wire [23:0] carrier_w  = {carrier_r, 16'h0000};
   wire [23:0] dev_w      = {8'h00, deviation_r, 8'h00};
   reg  [23:0] synth_nxt;

   // Friendly access shifts the carrier by the deviation for FSK data.
   always @* begin
      if (ctrl_r[`CTRL_DIRECT])
         synth_nxt = {freq2_r, freq1_r, freq0_r};
      else if (!tx_mode)
         synth_nxt = carrier_w + IF_OFFSET;
      else if (fsk && tx_line)
         synth_nxt = carrier_w + dev_w;
      else if (fsk)
         synth_nxt = carrier_w - dev_w;
      else
         synth_nxt = carrier_w;
   end

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_mode_r  <= 1'b0;
         rf_switch  <= 1'b0;
         pa_enable  <= 1'b0;
         rx_enable  <= 1'b0;
         synth_word <= 24'h000000;
      end else begin
         tx_mode_r  <= tx_mode;
         synth_word <= synth_nxt;
         if (tx_mode != tx_mode_r)
            rf_switch <= ~rf_switch;
         // Losing lock kills the amplifier three cycles later, after the pin synchroniser, to keep emission in band.
         pa_enable <= tx_mode && locked && (fsk || tx_line);
         rx_enable <= (mode == `MODE_RX) &&
                      (!strobe_en || wake_st_r == ST_ON);
      end
   end

   // ************************************************************
   // Analog settings from the active bank and the control register
   // ************************************************************
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lna_gain_step  <= 2'b00;
         pa_power_step  <= 2'b00;
         demod_adaptive <= 1'b1;
         lpf_bandwidth  <= 2'b00;
         band_code      <= 4'h0;
      end else begin
         lna_gain_step  <= band_act[`BAND_LNA_HI:`BAND_LNA_LO];
         pa_power_step  <= band_act[`BAND_PA_HI:`BAND_PA_LO];
         demod_adaptive <= fsk || !ctrl_r[`CTRL_FIXED_REF];
         lpf_bandwidth  <= rate_act[`RATE_SEL_HI:`RATE_SEL_LO];
         // Band group then LO trim; code 10 is not a valid group.
         band_code      <= band_act[`BAND_LO_HI:`BAND_SEL_LO];
      end
   end

   // ************************************************************
   // Register read port
   // ************************************************************
   wire [7:0] status_w = {1'b0, standby_active, bank_r, rf_switch,
                          lvd_mode, locked, pa_enable, lvd_status_r};

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         case (reg_addr)
            `ADDR_CTRL:      reg_rdata <= ctrl_r;
            `ADDR_BAND_A:    reg_rdata <= band_a_r;
            `ADDR_RATE_A:    reg_rdata <= rate_a_r;
            `ADDR_STATUS:    reg_rdata <= status_w;
            `ADDR_FREQ_0:    reg_rdata <= freq0_r;
            `ADDR_FREQ_1:    reg_rdata <= freq1_r;
            `ADDR_FREQ_2:    reg_rdata <= freq2_r;
            `ADDR_CARRIER:   reg_rdata <= carrier_r;
            `ADDR_DEVIATION: reg_rdata <= deviation_r;
            `ADDR_BAND_B:    reg_rdata <= band_b_r;
            `ADDR_RATE_B:    reg_rdata <= rate_b_r;
            default:         reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

endmodule

/* File: rf_ctl_props.sv */
// Checker of the transceiver control ports, bound to every instance.
// Assumes one crystal clock domain and an active-low reset.
`timescale 1ns/1ps
// **********
// Checker
// **********
module rf_ctl_props (
   // Clock and reset.
   input logic       sys_clk,
   input logic       reset_n,
   // Register port and lock pin.
   input logic [3:0] reg_addr,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata,
   input logic       pll_lock,
   // Outputs under watch.
   input logic       data_clk_en,
   input logic       dig_clk_en,
   input logic       if_ref_en,
   input logic       rf_switch,
   input logic       pa_enable,
   input logic       standby_active,
   input logic       lvd_mode,
   input logic [3:0] band_code,
   input logic       serial_data,
   input logic       serial_clk
);
   reg  [7:0] d_r, g_r, f_r;
   reg        dok_r, gok_r, fok_r;
   reg  [3:0] band_r;
   wire       keep = (band_code == band_r) && !standby_active && !lvd_mode;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Cycles since each divider pulse; a band change or standby voids the span.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         {d_r, g_r, f_r} <= 24'h0;
         {dok_r, gok_r, fok_r} <= 3'h0;
         band_r <= 4'h0;
      end else begin
         d_r <= data_clk_en ? 8'h01 : d_r + {7'h0, d_r != 8'hff};
         g_r <= dig_clk_en ? 8'h01 : g_r + {7'h0, g_r != 8'hff};
         f_r <= if_ref_en ? 8'h01 : f_r + {7'h0, f_r != 8'hff};
         dok_r <= (data_clk_en || dok_r) && keep;
         gok_r <= (dig_clk_en || gok_r) && keep;
         fok_r <= (if_ref_en || fok_r) && keep;
         band_r <= band_code;
      end
   end
   AST_DATA_DIV:
      assert property (data_clk_en && dok_r && !$past(reg_wr) |-> d_r == (band_code[0] ? 80 : 60))
      else $error("data clock period wrong");
   AST_DIG_DIV:
      assert property (dig_clk_en && gok_r && !$past(reg_wr) |-> g_r == (band_code[0] ? 40 : 30))
      else $error("digital clock period wrong");
   AST_IF_DIV:
      assert property (if_ref_en && fok_r && !$past(reg_wr) |-> f_r == (band_code[0] ? 12 : 9))
      else $error("IF reference period wrong");
   AST_SWITCH_CAUSE:
      assert property ($changed(rf_switch) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0)
      else $error("switch moved without a mode write");
   AST_TX_UNLOCK:
      assert property (!pll_lock [*5] |-> !pa_enable)
      else $error("transmitting while out of lock");
   AST_RX_UNLOCK:
      assert property (!pll_lock [*5] |-> !serial_data && !serial_clk)
      else $error("receive data passed while out of lock");
   AST_LVD_NO_STANDBY:
      assert property (lvd_mode |-> !standby_active)
      else $error("standby entered with monitor enabled");
   AST_SCLK_PULSE:
      assert property (serial_clk |=> !serial_clk)
      else $error("serial clock pulse too long");
   AST_STATUS_BITS:
      assert property (reg_rd && reg_addr == 4'h3 |=>
                       reg_rdata[4:3] == {$past(rf_switch), $past(lvd_mode)})
      else $error("status bits disagree with outputs");
   AST_RDATA_IDLE:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside the answer cycle");
endmodule

bind rf_transceiver_control rf_ctl_props i_props (.sys_clk, .reset_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .pll_lock, .data_clk_en, .dig_clk_en, .if_ref_en, .rf_switch,
   .pa_enable, .standby_active, .lvd_mode, .band_code, .serial_data, .serial_clk);

/* File: rf_ctl_partner.sv */
// Far-side model: microcontroller data pin and the analog status inputs.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
// **********
// Partner
// **********
module rf_ctl_partner (
   // Clock.
   input  logic sys_clk,
   // Pins toward the block.
   output logic monitored_supply,
   output logic pll_lock,
   output logic demod_data,
   output logic tx_coded_data
);
   // Supply good, synthesizer locked, quiet data lines at time zero.
   initial begin
      monitored_supply = 1'b0;
      pll_lock = 1'b1;
      demod_data = 1'b0;
      tx_coded_data = 1'b0;
   end
   // Move the pins together just after an edge, then hold them.
   task automatic pins(input logic low, lock, rx, tx);
      monitored_supply <= low;
      pll_lock <= lock;
      demod_data <= rx;
      tx_coded_data <= tx;
      @(posedge sys_clk);
   endtask
   // Manchester frame, top bit first; a rising mid-bit edge is a one.
   task automatic frame(input logic [7:0] b, input int half);
      for (int i = 7; i >= 0; i--) begin
         demod_data <= !b[i];
         repeat (half) @(posedge sys_clk);
         demod_data <= b[i];
         repeat (half) @(posedge sys_clk);
      end
   endtask
endmodule

/* File: tb_rf_transceiver_control.sv */
// Self-checking bench for the transceiver control block.
// Assumes the checker binds itself and the partner drives the analog pins.
`timescale 1ns/1ps
// **********
// Bench
// **********
module tb_rf_transceiver_control;
   logic        sys_clk, reset_n, reg_wr, reg_rd, sw;
   logic [3:0]  reg_addr, band_code;
   logic [7:0]  reg_wdata, reg_rdata, got, pm;
   logic        monitored_supply, pll_lock, demod_data, tx_coded_data;
   logic        data_clk_en, dig_clk_en, if_ref_en, rf_switch, pa_enable, rx_enable;
   logic        standby_active, lvd_mode, demod_adaptive, serial_data, serial_clk;
   logic [1:0]  lna_gain_step, pa_power_step, lpf_bandwidth;
   logic [23:0] synth_word;
   logic [7:0]  mq [6] = '{8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01};
   logic [7:0]  bq [4] = '{8'h30, 8'h68, 8'h95, 8'hcf};
   logic [7:0]  dq [3] = '{8'h00, 8'h20, 8'h30};
   int          failures = 0, num_checks = 0, nb, per [3], last [3];

   rf_transceiver_control #(.STROBE_ON_TICKS(2), .STROBE_OFF_TICKS(3)) i_dut (
      .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .monitored_supply, .pll_lock, .demod_data, .tx_coded_data, .data_clk_en,
      .dig_clk_en, .if_ref_en, .rf_switch, .pa_enable, .rx_enable, .standby_active,
      .lvd_mode, .lna_gain_step, .pa_power_step, .demod_adaptive, .lpf_bandwidth,
      .band_code, .synth_word, .serial_data, .serial_clk);
   rf_ctl_partner i_far (.sys_clk, .monitored_supply, .pll_lock, .demod_data, .tx_coded_data);

   // 40 MHz crystal clock.
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Compare and count; case inequality so an unknown never matches.
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One-cycle write strobe, then an idle edge so strobes never merge.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Read strobe; the answer is taken at the following edge only.
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk("register", {16'h0, reg_rdata}, {16'h0, e});
   endtask
   // Room for the two-flop pin synchronisers and the output registers.
   task automatic settle;
      repeat (6) @(posedge sys_clk);
   endtask
   // Spacing of the last two pulses of each divider output.
   task automatic measure;
      logic [2:0] en;
      per = '{0, 0, 0};
      last = '{0, 0, 0};
      for (int t = 1; t < 200; t++) begin
         @(posedge sys_clk);
         en = {if_ref_en, dig_clk_en, data_clk_en};
         for (int k = 0; k < 3; k++) if (en[k] === 1'b1) begin
            per[k] = t - last[k];
            last[k] = t;
         end
      end
   endtask
   // Gather decoded bits at each serial clock pulse.
   task automatic collect(input int n);
      nb = 0;
      for (int t = 0; t < n; t++) begin
         @(posedge sys_clk);
         if (serial_clk === 1'b1) begin
            got = {got[6:0], serial_data};
            nb++;
         end
      end
   endtask
   // Verdict and end of run.
   task automatic test_done;
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // A hang counts as a mismatch.
   initial begin
      repeat (100000) @(posedge sys_clk);
      failures++;
      test_done;
   end

   // Main sequence.
   initial begin
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      settle;
      for (int a = 0; a < 16; a++) if (a != 3) rchk(a[3:0], 8'h00);
      wr(4'h3, 8'hff);
      rchk(4'h3, 8'h04);
      wr(4'h7, 8'h5a);
      wr(4'h1, 8'h95);
      wr(4'h0, 8'h02);
      settle;
      chk("standby", {standby_active, lvd_mode}, 2'b10);
      rchk(4'h7, 8'h5a);
      rchk(4'h1, 8'h95);
      wr(4'h0, 8'h06);
      settle;
      chk("monitor mode", {standby_active, lvd_mode}, 2'b01);
      wr(4'h0, 8'h00);
      i_far.pins(1'b1, 1'b1, 1'b0, 1'b0);
      repeat (100) @(posedge sys_clk);
      rchk(4'h3, 8'h04);
      wr(4'h0, 8'h04);
      repeat (100) @(posedge sys_clk);
      rchk(4'h3, 8'h05);
      repeat (100) @(posedge sys_clk);
      rchk(4'h3, 8'h05);
      repeat (100) @(posedge sys_clk);
      i_far.pins(1'b0, 1'b1, 1'b0, 1'b0);
      settle;
      rchk(4'h3, 8'h05);
      rchk(4'h3, 8'h04);
      // Mode walk; standby in between must not move the switch.
      pm = 8'h00;
      sw = 1'b0;
      foreach (mq[i]) begin
         wr(4'h0, mq[i]);
         settle;
         sw ^= (mq[i] != pm) && mq[i] != 8'h02 && pm != 8'h02;
         pm = mq[i];
         chk("rf switch", rf_switch, sw);
      end
      i_far.pins(1'b0, 1'b1, 1'b0, 1'b1);
      settle;
      chk("carrier on", pa_enable, 1'b1);
      i_far.pins(1'b0, 1'b1, 1'b0, 1'b0);
      settle;
      chk("carrier off", pa_enable, 1'b0);
      wr(4'h0, 8'h11);
      settle;
      chk("fsk carrier", pa_enable, 1'b1);
      i_far.pins(1'b0, 1'b0, 1'b0, 1'b0);
      settle;
      chk("unlocked carrier", pa_enable, 1'b0);
      i_far.pins(1'b0, 1'b1, 1'b0, 1'b0);
      foreach (dq[i]) begin
         wr(4'h0, dq[i]);
         settle;
         chk("adaptive ref", demod_adaptive, !(dq[i][5] && !dq[i][4]));
      end
      foreach (bq[i]) begin
         wr(4'h1, bq[i]);
         wr(4'h2, i[7:0]);
         settle;
         chk("band", band_code, bq[i][3:0]);
         chk("lna step", lna_gain_step, bq[i][5:4]);
         chk("power step", pa_power_step, bq[i][7:6]);
         chk("lpf", lpf_bandwidth, i[1:0]);
         measure;
         chk("data divider", per[0], bq[i][0] ? 80 : 60);
         chk("digital divider", per[1], bq[i][0] ? 40 : 30);
         chk("if divider", per[2], bq[i][0] ? 12 : 9);
      end
      wr(4'h9, 8'h0d);
      wr(4'h0, 8'h80);
      settle;
      chk("bank b", band_code, 4'hd);
      wr(4'h0, 8'h00);
      settle;
      chk("friendly word", synth_word, 24'h5a0400);
      wr(4'h4, 8'h12);
      wr(4'h5, 8'h34);
      wr(4'h6, 8'h56);
      wr(4'h0, 8'h40);
      settle;
      chk("direct word", synth_word, 24'h563412);
      wr(4'h0, 8'h00);
      i_far.pins(1'b0, 1'b1, 1'b1, 1'b0);
      settle;
      chk("raw data", serial_data, 1'b1);
      i_far.pins(1'b0, 1'b0, 1'b1, 1'b0);
      settle;
      chk("raw unlocked", serial_data, 1'b0);
      i_far.pins(1'b0, 1'b1, 1'b0, 1'b0);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h08);
      // Half-bit of 15 digital ticks at a 30-cycle tick.
      fork
         i_far.frame(8'hb2, 450);
         collect(8300);
      join
      chk("decoded count", nb, 8);
      chk("decoded bits", got, 8'hb2);
      // Strobe: 2 on and 3 off data ticks, so 240 of any 600 cycles.
      wr(4'h2, 8'h04);
      repeat (100) @(posedge sys_clk);
      nb = 0;
      repeat (600) begin
         @(posedge sys_clk);
         nb += rx_enable;
      end
      chk("rx window", nb, 240);
      test_done;
   end
endmodule
